// *** psram_cfg_pkg.sv ***
// constants and types for the configuration, power and refresh control block
package psram_cfg_pkg;
    // clock rate of sys_clk
    localparam int CLK_MHZ = 250;
    // register select codes on the configuration port
    localparam logic SEL_FIRST_CFG = 1'b0;
    localparam logic SEL_SECOND_CFG = 1'b1;
    // first configuration register layout
    localparam logic [15:0] FIRST_CFG_RESET = 16'h8000;
    localparam int FIRST_PWR_BIT = 15;
    localparam int DRIVE_LSB = 12;
    localparam int DRIVE_W = 3;
    localparam logic [2:0] DRIVE_RESET = 3'h0;
    // second configuration register layout
    localparam logic [15:0] SECOND_CFG_RESET = 16'hFFC1;
    localparam logic [15:0] SECOND_FIXED_MASK = 16'hFF83;
    localparam int CLK_TYPE_BIT = 6;
    localparam int SLEEP_BIT = 5;
    localparam int PART_LSB = 2;
    localparam int PART_W = 3;
    localparam logic [1:0] INTERVAL_CODE = 2'h1;
    // partial array refresh encodings
    localparam logic [2:0] PART_FULL = 3'h0;
    localparam logic [2:0] PART_BOT_HALF = 3'h1;
    localparam logic [2:0] PART_BOT_QUARTER = 3'h2;
    localparam logic [2:0] PART_BOT_EIGHTH = 3'h3;
    localparam logic [2:0] PART_RESERVED = 3'h4;
    localparam logic [2:0] PART_TOP_HALF = 3'h5;
    localparam logic [2:0] PART_TOP_QUARTER = 3'h6;
    localparam logic [2:0] PART_TOP_EIGHTH = 3'h7;
    // refresh interval, a longest time, so rounded down
    localparam int REFRESH_INTERVAL_NS = 4000;
    localparam int REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_NS * CLK_MHZ / 1000;
    // power down entry time, a longest time, at least one cycle
    localparam int PD_ENTRY_NS = 10;
    localparam int PD_ENTRY_RAW = PD_ENTRY_NS * CLK_MHZ / 1000;
    localparam int PD_ENTRY_CYC = (PD_ENTRY_RAW < 1) ? 1 : PD_ENTRY_RAW;
    // cycles one row refresh occupies the array
    localparam int REFRESH_OP_CYC = 8;
    // power state machine
    typedef enum logic [1:0] {
        PWR_NORMAL = 2'b00,
        PWR_ENTERING = 2'b01,
        PWR_DEEP = 2'b10,
        PWR_SLEEP = 2'b11
    } pwr_state_t;
    // refresh scheduler state machine
    typedef enum logic [1:0] {
        REF_IDLE = 2'b00,
        REF_PENDING = 2'b01,
        REF_BUSY = 2'b10
    } ref_state_t;
endpackage

// *** refresh_if.sv ***
// signals between the control block and its refresh scheduler
`timescale 1ns/1ps
interface refresh_if #(parameter int ROW_BITS = 13);
    logic enable; // refresh allowed
    logic clear; // restart scheduler after reset pin
    logic [2:0] part_sel; // partial array selection
    logic access_active; // host transaction in progress
    logic pending; // refresh due or running
    logic busy; // array busy refreshing
    logic [ROW_BITS-1:0] row; // row being refreshed
    modport ctrl (output enable, output clear, output part_sel, output access_active,
                  input pending, input busy, input row);
    modport sched (input enable, input clear, input part_sel, input access_active,
                   output pending, output busy, output row);
endinterface

// *** refresh_sched.sv ***
// distributed self-refresh scheduler with partial array support
`timescale 1ns/1ps
module refresh_sched #(
    parameter int ROW_BITS = 13
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    refresh_if.sched rif
);
    localparam int TMR_W = $clog2(psram_cfg_pkg::REFRESH_INTERVAL_CYC + 1);
    localparam int OP_W = $clog2(psram_cfg_pkg::REFRESH_OP_CYC + 1);
    localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(psram_cfg_pkg::REFRESH_INTERVAL_CYC - 1);
    localparam logic [OP_W-1:0] OP_LAST = OP_W'(psram_cfg_pkg::REFRESH_OP_CYC - 1);

    // lowest row of the refreshed region
    function automatic logic [ROW_BITS-1:0] region_lo(input logic [2:0] sel);
        logic [ROW_BITS-1:0] top;
        top = '1;
        unique case (sel)
            psram_cfg_pkg::PART_TOP_HALF: region_lo = ~(top >> 1);
            psram_cfg_pkg::PART_TOP_QUARTER: region_lo = ~(top >> 2);
            psram_cfg_pkg::PART_TOP_EIGHTH: region_lo = ~(top >> 3);
            default: region_lo = '0;
        endcase
    endfunction

    // highest row of the refreshed region; reserved code refreshes all
    function automatic logic [ROW_BITS-1:0] region_hi(input logic [2:0] sel);
        logic [ROW_BITS-1:0] top;
        top = '1;
        unique case (sel)
            psram_cfg_pkg::PART_BOT_HALF: region_hi = top >> 1;
            psram_cfg_pkg::PART_BOT_QUARTER: region_hi = top >> 2;
            psram_cfg_pkg::PART_BOT_EIGHTH: region_hi = top >> 3;
            default: region_hi = top;
        endcase
    endfunction

    psram_cfg_pkg::ref_state_t state_q, state_d; // scheduler state
    logic [TMR_W-1:0] tmr_q, tmr_d; // interval timer
    logic [OP_W-1:0] op_q, op_d; // refresh operation timer
    logic [ROW_BITS-1:0] row_q, row_d; // next row to refresh

    // next state: one row per interval, spread evenly
    always_comb begin
        state_d = state_q;
        tmr_d = tmr_q;
        op_d = op_q;
        row_d = row_q;
        if (!rif.enable || rif.clear) begin
            // stopped: nothing pending, timer restarts on re-enable
            state_d = psram_cfg_pkg::REF_IDLE;
            tmr_d = '0;
            op_d = '0;
        end else begin
            tmr_d = (tmr_q == TMR_LAST) ? '0 : tmr_q + 1'b1;
            unique case (state_q)
                psram_cfg_pkg::REF_IDLE: begin
                    if (tmr_q == TMR_LAST) begin
                        state_d = psram_cfg_pkg::REF_PENDING;
                    end
                end
                psram_cfg_pkg::REF_PENDING: begin
                    if (!rif.access_active) begin
                        state_d = psram_cfg_pkg::REF_BUSY;
                        op_d = '0;
                    end
                end
                psram_cfg_pkg::REF_BUSY: begin
                    op_d = op_q + 1'b1;
                    if (op_q == OP_LAST) begin
                        state_d = psram_cfg_pkg::REF_IDLE;
                        if (row_q >= region_hi(rif.part_sel) || row_q < region_lo(rif.part_sel)) begin
                            row_d = region_lo(rif.part_sel);
                        end else begin
                            row_d = row_q + 1'b1;
                        end
                    end
                end
                default: state_d = psram_cfg_pkg::REF_IDLE;
            endcase
        end
    end

    // scheduler registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= psram_cfg_pkg::REF_IDLE;
            tmr_q <= '0;
            op_q <= '0;
            row_q <= '0;
        end else begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            op_q <= op_d;
            row_q <= row_d;
        end
    end

    assign rif.pending = (state_q != psram_cfg_pkg::REF_IDLE);
    assign rif.busy = (state_q == psram_cfg_pkg::REF_BUSY);
    assign rif.row = row_q;
endmodule

// *** psram_power_refresh_config.sv ***
// configuration registers, power states and refresh control of the memory device
`timescale 1ns/1ps
module psram_power_refresh_config #(
    parameter int ROW_BITS = 13
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic hw_reset_n,
    input wire logic cs_n,
    input wire logic reg_wr,
    input wire logic reg_sel,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic access_start,
    input wire logic access_active,
    output logic [2:0] drive_strength,
    output logic clock_single_ended,
    output logic [2:0] refresh_part_sel,
    output logic strobe_ca_high,
    output logic lowest_power,
    output logic retention_sleep,
    output logic inputs_ignored,
    output logic refresh_busy,
    output logic [ROW_BITS-1:0] refresh_row
);
    localparam int PD_W = $clog2(psram_cfg_pkg::PD_ENTRY_CYC + 1);
    localparam logic [PD_W-1:0] PD_LAST = PD_W'(psram_cfg_pkg::PD_ENTRY_CYC - 1);

    // writable bits of the second register merged with its fixed bits
    // a host that forgets the reserved ones still reads them back set
    function automatic logic [15:0] second_fixed(input logic [15:0] v);
        second_fixed = (v & ~psram_cfg_pkg::SECOND_FIXED_MASK) |
                       (psram_cfg_pkg::SECOND_CFG_RESET & psram_cfg_pkg::SECOND_FIXED_MASK);
    endfunction

    refresh_if #(.ROW_BITS(ROW_BITS)) rif ();

    logic [1:0] cs_sync_q; // select pin synchroniser
    logic [1:0] rst_sync_q; // reset pin synchroniser
    logic cs_low; // synchronised select level, low active
    logic pin_reset; // synchronised hardware reset pin

    // two flops on each pin before any logic looks at it
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            // both pins idle high, so no false select or reset after power-on
            cs_sync_q <= 2'h3;
            rst_sync_q <= 2'h3;
        end else begin
            cs_sync_q <= {cs_sync_q[0], cs_n};
            rst_sync_q <= {rst_sync_q[0], hw_reset_n};
        end
    end
    assign cs_low = ~cs_sync_q[1];
    assign pin_reset = ~rst_sync_q[1];

    psram_cfg_pkg::pwr_state_t pwr_q, pwr_d; // power state
    logic [PD_W-1:0] pd_cnt_q, pd_cnt_d; // power down entry timer
    logic cs_seen_low_q, cs_seen_low_d; // select went low during power down
    logic [15:0] cfg0_q, cfg0_d; // first configuration register
    logic [15:0] cfg1_q, cfg1_d; // second configuration register, writable bits
    logic [15:0] rdata_q, rdata_d; // read data
    logic strobe_q, strobe_d; // extra latency flag for current access
    logic writes_taken; // register port accepted

    // only select and reset pin matter, and reg_sel still steers reads
    // power down drops register writes without any error response
    assign writes_taken = (pwr_q != psram_cfg_pkg::PWR_DEEP) && reg_wr;

    // next state of power, registers and latency flag
    always_comb begin
        pwr_d = pwr_q;
        pd_cnt_d = pd_cnt_q;
        cs_seen_low_d = cs_seen_low_q;
        cfg0_d = cfg0_q;
        cfg1_d = cfg1_q;
        strobe_d = strobe_q;
        // reads return the selected register; interval code is fixed
        // read-only interval field
        rdata_d = (reg_sel == psram_cfg_pkg::SEL_SECOND_CFG) ?
                  second_fixed(cfg1_q) : cfg0_q;
        if (writes_taken) begin
            if (reg_sel == psram_cfg_pkg::SEL_SECOND_CFG) begin
                cfg1_d = second_fixed(reg_wdata);
            end else begin
                cfg0_d = reg_wdata;
            end
        end
        // flag means doubled latency
        // held to the end of the access, one answer per command
        if (access_start && pwr_q != psram_cfg_pkg::PWR_DEEP) begin
            strobe_d = rif.pending;
        end else if (!access_active) begin
            strobe_d = 1'b0;
        end
        unique case (pwr_q)
            psram_cfg_pkg::PWR_NORMAL: begin
                if (writes_taken && reg_sel == psram_cfg_pkg::SEL_FIRST_CFG &&
                    !reg_wdata[psram_cfg_pkg::FIRST_PWR_BIT]) begin
                    pwr_d = psram_cfg_pkg::PWR_ENTERING;
                    pd_cnt_d = '0;
                end else if (writes_taken && reg_sel == psram_cfg_pkg::SEL_SECOND_CFG &&
                             reg_wdata[psram_cfg_pkg::SLEEP_BIT]) begin
                    pwr_d = psram_cfg_pkg::PWR_SLEEP;
                end
            end
            psram_cfg_pkg::PWR_ENTERING: begin
                // reach power down within entry time
                pd_cnt_d = pd_cnt_q + 1'b1;
                if (pd_cnt_q == PD_LAST) begin
                    pwr_d = psram_cfg_pkg::PWR_DEEP;
                    cs_seen_low_d = 1'b0;
                end
            end
            psram_cfg_pkg::PWR_DEEP: begin
                // low then high pulse on select wakes
                if (cs_low) begin
                    cs_seen_low_d = 1'b1;
                end else if (cs_seen_low_q) begin
                    // registers come back as after power-on
                    pwr_d = psram_cfg_pkg::PWR_NORMAL;
                    cs_seen_low_d = 1'b0;
                    cfg0_d = psram_cfg_pkg::FIRST_CFG_RESET;
                    cfg1_d = psram_cfg_pkg::SECOND_CFG_RESET;
                end
            end
            psram_cfg_pkg::PWR_SLEEP: begin
                // select low exits and clears bit
                if (cs_low) begin
                    pwr_d = psram_cfg_pkg::PWR_NORMAL;
                    cfg1_d[psram_cfg_pkg::SLEEP_BIT] = 1'b0;
                end
            end
        endcase
        // reset pin ends sleep and power down
        if (pin_reset) begin
            pwr_d = psram_cfg_pkg::PWR_NORMAL;
            pd_cnt_d = '0;
            cs_seen_low_d = 1'b0;
            cfg0_d = psram_cfg_pkg::FIRST_CFG_RESET;
            cfg1_d = psram_cfg_pkg::SECOND_CFG_RESET;
            strobe_d = 1'b0;
        end
    end

    // power, register and flag storage
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwr_q <= psram_cfg_pkg::PWR_NORMAL;
            pd_cnt_q <= '0;
            cs_seen_low_q <= 1'b0;
            cfg0_q <= psram_cfg_pkg::FIRST_CFG_RESET;
            cfg1_q <= psram_cfg_pkg::SECOND_CFG_RESET;
            rdata_q <= '0;
            strobe_q <= 1'b0;
        end else begin
            pwr_q <= pwr_d;
            pd_cnt_q <= pd_cnt_d;
            cs_seen_low_q <= cs_seen_low_d;
            cfg0_q <= cfg0_d;
            cfg1_q <= cfg1_d;
            rdata_q <= rdata_d;
            strobe_q <= strobe_d;
        end
    end

    // pin reset restarts refresh
    // refresh already stops while entering, well inside the entry time;
    // a row cut short there is lost with the rest of the array anyway
    assign rif.enable = (pwr_q == psram_cfg_pkg::PWR_NORMAL) ||
                        (pwr_q == psram_cfg_pkg::PWR_SLEEP);
    assign rif.clear = pin_reset;
    assign rif.part_sel = cfg1_q[psram_cfg_pkg::PART_LSB +: psram_cfg_pkg::PART_W];
    // relies on host bounding select-low time
    assign rif.access_active = access_active;

    refresh_sched #(.ROW_BITS(ROW_BITS)) u_sched (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .rif(rif)
    );

    // outputs taken from flops, power and refresh flags decoded from state flops
    // drive field to pads
    assign drive_strength = cfg0_q[psram_cfg_pkg::DRIVE_LSB +: psram_cfg_pkg::DRIVE_W];
    assign clock_single_ended = cfg1_q[psram_cfg_pkg::CLK_TYPE_BIT];
    assign refresh_part_sel = rif.part_sel;
    assign reg_rdata = rdata_q;
    assign strobe_ca_high = strobe_q;
    assign lowest_power = (pwr_q == psram_cfg_pkg::PWR_DEEP);
    assign retention_sleep = (pwr_q == psram_cfg_pkg::PWR_SLEEP);
    assign inputs_ignored = (pwr_q == psram_cfg_pkg::PWR_DEEP);
    assign refresh_busy = rif.busy;
    assign refresh_row = rif.row;
endmodule

// *** psram_power_refresh_config_monitor.sv ***
// bound checker for the configuration, power and refresh block
`timescale 1ns/1ps
module psram_power_refresh_config_monitor #(
    parameter int ROW_BITS = 13
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic hw_reset_n,
    input wire logic cs_n,
    input wire logic reg_wr,
    input wire logic reg_sel,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic access_start,
    input wire logic access_active,
    input wire logic [2:0] drive_strength,
    input wire logic clock_single_ended,
    input wire logic [2:0] refresh_part_sel,
    input wire logic strobe_ca_high,
    input wire logic lowest_power,
    input wire logic retention_sleep,
    input wire logic inputs_ignored,
    input wire logic refresh_busy,
    input wire logic [ROW_BITS-1:0] refresh_row
);
    default clocking cb @(posedge sys_clk);
    endclocking
    // the pin reset also restarts everything, so checks pause while it is low
    default disable iff (sys_rst || !hw_reset_n);
    // a write the block accepts
    logic wr_ok;
    assign wr_ok = reg_wr && !lowest_power;
    property p_drive;
        wr_ok && !reg_sel |=> drive_strength == $past(reg_wdata[14:12]);
    endproperty
    a_drive: assert property (p_drive) else $error("drive field not stored");
    property p_clk_type;
        wr_ok && reg_sel |=> clock_single_ended == $past(reg_wdata[6]);
    endproperty
    a_clk_type: assert property (p_clk_type) else $error("clock type not stored");
    property p_part;
        wr_ok && reg_sel |=> refresh_part_sel == $past(reg_wdata[4:2]);
    endproperty
    a_part: assert property (p_part) else $error("partial refresh not stored");
    property p_sleep_in;
        wr_ok && reg_sel && reg_wdata[5] && cs_n && $past(cs_n) && $past(cs_n, 2)
            |=> retention_sleep;
    endproperty
    a_sleep_in: assert property (p_sleep_in) else $error("sleep not entered");
    property p_sleep_out;
        retention_sleep && !cs_n ##1 !cs_n |-> ##[0:4] !retention_sleep;
    endproperty
    a_sleep_out: assert property (p_sleep_out) else $error("sleep not left");
    property p_pd_in;
        wr_ok && !reg_sel && !reg_wdata[15] |-> ##[1:5] lowest_power;
    endproperty
    a_pd_in: assert property (p_pd_in) else $error("power down not entered");
    property p_ignore;
        inputs_ignored && reg_wr |=> !lowest_power || $stable(drive_strength);
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignore flag wrong");
    property p_pd_norefresh;
        lowest_power |-> !refresh_busy;
    endproperty
    a_pd_norefresh: assert property (p_pd_norefresh) else $error("refresh in power down");
    property p_ref_len;
        $rose(refresh_busy) |-> (refresh_busy [*8] ##1 !refresh_busy) or (##[1:9] lowest_power);
    endproperty
    a_ref_len: assert property (p_ref_len) else $error("refresh length wrong");
    property p_ref_gap;
        access_active && !refresh_busy |=> !refresh_busy;
    endproperty
    a_ref_gap: assert property (p_ref_gap) else $error("refresh during access");
    property p_strobe;
        access_start && refresh_busy |=> strobe_ca_high;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe not raised");
    property p_rd_second;
        reg_sel && $past(reg_sel) && !$past(sys_rst)
            |-> reg_rdata[15:7] == 9'h1FF && reg_rdata[1:0] == 2'h1;
    endproperty
    a_rd_second: assert property (p_rd_second) else $error("fixed bits wrong");
    c_sleep: cover property (retention_sleep ##1 !retention_sleep);
    c_pd: cover property ($fell(lowest_power));
    c_strobe: cover property (access_start && refresh_busy);
endmodule
bind psram_power_refresh_config psram_power_refresh_config_monitor #(.ROW_BITS(ROW_BITS)) mon (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .hw_reset_n(hw_reset_n), .cs_n(cs_n),
    .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .access_start(access_start), .access_active(access_active),
    .drive_strength(drive_strength), .clock_single_ended(clock_single_ended),
    .refresh_part_sel(refresh_part_sel), .strobe_ca_high(strobe_ca_high),
    .lowest_power(lowest_power), .retention_sleep(retention_sleep),
    .inputs_ignored(inputs_ignored), .refresh_busy(refresh_busy), .refresh_row(refresh_row));

// *** host_model.sv ***
// host controller model driving select, register and access lines
`timescale 1ns/1ps
module host_model (
    input wire logic sys_clk,
    output logic hw_reset_n,
    output logic cs_n,
    output logic reg_wr,
    output logic reg_sel,
    output logic [15:0] reg_wdata,
    output logic access_start,
    output logic access_active
);
    // idle bus: deselected, no strobes
    initial begin
        hw_reset_n = 1'b1;
        cs_n = 1'b1;
        reg_wr = 1'b0;
        reg_sel = 1'b0;
        reg_wdata = 16'h0000;
        access_start = 1'b0;
        access_active = 1'b0;
    end
    // every change lands just after the rising edge
    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic sel, input logic [15:0] data);
        reg_sel = sel;
        reg_wdata = sel ? (data | 16'hFF80) : data;
        reg_wr = 1'b1;
        step();
        reg_wr = 1'b0;
    endtask
    // read data follows the select one cycle later
    task automatic sel_reg(input logic sel);
        reg_sel = sel;
        step();
        step();
    endtask
    // wake by select pulse, synchroniser needs a few edges
    task automatic cs_pulse(input int low);
        cs_n = 1'b0;
        repeat (low) step();
        cs_n = 1'b1;
        repeat (4) step();
    endtask
    // pin reset held past the synchroniser
    task automatic pin_reset();
        hw_reset_n = 1'b0;
        repeat (4) step();
        hw_reset_n = 1'b1;
        repeat (4) step();
    endtask
    // callers keep each access well under the refresh interval
    // on opens an access with its command phase, off closes it
    task automatic acc(input logic on);
        cs_n = ~on;
        access_start = on;
        access_active = on;
        step();
        access_start = 1'b0;
    endtask
endmodule

// *** psram_power_refresh_config_tb.sv ***
// self-checking bench for the configuration, power and refresh block
`timescale 1ns/1ps
module psram_power_refresh_config_tb;
    logic sys_clk, sys_rst, hw_reset_n, cs_n, reg_wr, reg_sel, access_start, access_active;
    logic [15:0] reg_wdata, reg_rdata;
    logic [2:0] drive_strength, refresh_part_sel;
    logic clock_single_ended, strobe_ca_high, lowest_power, retention_sleep;
    logic inputs_ignored, refresh_busy;
    logic [12:0] refresh_row;
    int err_count = 0;
    int samples_checked = 0;
    psram_power_refresh_config dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .hw_reset_n(hw_reset_n), .cs_n(cs_n), .reg_wr(reg_wr), .reg_sel(reg_sel),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .access_start(access_start),
        .access_active(access_active), .drive_strength(drive_strength),
        .clock_single_ended(clock_single_ended), .refresh_part_sel(refresh_part_sel),
        .strobe_ca_high(strobe_ca_high), .lowest_power(lowest_power),
        .retention_sleep(retention_sleep), .inputs_ignored(inputs_ignored),
        .refresh_busy(refresh_busy), .refresh_row(refresh_row));
    host_model host (.sys_clk(sys_clk), .hw_reset_n(hw_reset_n), .cs_n(cs_n),
        .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
        .access_start(access_start), .access_active(access_active));
    // 250 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // bounded wait for the refresh flag to reach a level
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 1200; i++) begin
            if (refresh_busy === lvl) return;
            host.step();
        end
        err_count++;
        $display("CHECK FAILED refresh_busy wait expected %h seen timeout", lvl);
        test_done();
    endtask
    task automatic t_reset_vals();
        chk("drive_strength", 16'(drive_strength), 16'h0000);
        chk("clock_single_ended", 16'(clock_single_ended), 16'h0001);
        chk("refresh_part_sel", 16'(refresh_part_sel), 16'h0000);
        host.sel_reg(1'b1);
        chk("second_config_reg", reg_rdata, 16'hFFC1);
    endtask
    // every partial refresh code and both clock types
    task automatic t_second_fields();
        logic [2:0] p;
        for (int i = 0; i < 8; i++) begin
            p = 3'(i);
            host.wr(1'b1, {9'h000, p[0], 1'b0, p, 2'h0});
            host.sel_reg(1'b1);
            chk("refresh_part_sel", 16'(refresh_part_sel), 16'(p));
            chk("clock_single_ended", 16'(clock_single_ended), 16'(p[0]));
            chk("second_config_reg", reg_rdata, {9'h1FF, p[0], 1'b0, p, 2'h1});
        end
    endtask
    task automatic t_drive();
        logic [2:0] d;
        for (int i = 0; i < 8; i++) begin
            d = 3'(i);
            host.wr(1'b0, {1'b1, d, 12'h000});
            host.step();
            chk("drive_strength", 16'(drive_strength), 16'(d));
        end
    endtask
    task automatic t_sleep();
        host.wr(1'b1, 16'h0060);
        host.sel_reg(1'b1);
        chk("retention_sleep", 16'(retention_sleep), 16'h0001);
        chk("second_config_reg", reg_rdata, 16'hFFE1);
        host.cs_pulse(6);
        chk("retention_sleep", 16'(retention_sleep), 16'h0000);
        chk("second_config_reg", reg_rdata, 16'hFFC1);
        host.wr(1'b1, 16'h0060);
        host.sel_reg(1'b0);
        host.pin_reset();
        chk("retention_sleep", 16'(retention_sleep), 16'h0000);
        chk("drive_strength", 16'(drive_strength), 16'h0000);
    endtask
    task automatic t_power_down();
        int busy_seen;
        busy_seen = 0;
        host.wr(1'b0, 16'h3000);
        repeat (6) host.step();
        chk("lowest_power", 16'(lowest_power), 16'h0001);
        chk("inputs_ignored", 16'(inputs_ignored), 16'h0001);
        // a write that would leave power down is dropped
        host.wr(1'b0, 16'hF000);
        repeat (1100) begin
            host.step();
            busy_seen += int'(refresh_busy === 1'b1);
        end
        chk("lowest_power", 16'(lowest_power), 16'h0001);
        chk("refresh_busy count", 16'(busy_seen), 16'h0000);
        host.cs_pulse(3);
        chk("lowest_power", 16'(lowest_power), 16'h0000);
        chk("inputs_ignored", 16'(inputs_ignored), 16'h0000);
        host.sel_reg(1'b0);
        chk("first_config_reg", reg_rdata, 16'h8000);
        host.wr(1'b0, 16'h8000);
    endtask
    task automatic t_refresh();
        int n;
        int rose;
        n = 0;
        rose = 0;
        wait_busy(1'b1);
        while (refresh_busy === 1'b1 && n < 20) begin
            host.step();
            n++;
        end
        chk("refresh length", 16'(n), 16'h0008);
        chk("refresh_row", 16'(refresh_row), 16'h0001);
        host.acc(1'b1);
        chk("strobe_ca_high idle", 16'(strobe_ca_high), 16'h0000);
        host.acc(1'b0);
        // top half only: the next row must jump into that region
        host.wr(1'b1, 16'h0054);
        repeat (974) host.step();
        // next refresh falls due inside this access and must wait
        host.acc(1'b1);
        repeat (60) begin
            host.step();
            rose += int'(refresh_busy === 1'b1);
        end
        chk("refresh during access", 16'(rose), 16'h0000);
        host.acc(1'b0);
        host.step();
        chk("deferred refresh", 16'(refresh_busy), 16'h0001);
        host.acc(1'b1);
        chk("strobe_ca_high pending", 16'(strobe_ca_high), 16'h0001);
        host.acc(1'b0);
        wait_busy(1'b0);
        chk("refresh_row region", 16'(refresh_row), 16'h1000);
    endtask
    initial begin
        sys_rst = 1'b1;
        repeat (8) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        host.step();
        t_reset_vals();
        t_second_fields();
        t_drive();
        t_sleep();
        t_power_down();
        t_refresh();
        test_done();
    end
endmodule
